// >>> i2c_slave_port_pkg.sv
package i2c_slave_port_pkg;

    // Mode select codes for the port.
    localparam logic [3:0] MODE_SLAVE7      = 4'h6;
    localparam logic [3:0] MODE_SLAVE10     = 4'h7;
    localparam logic [3:0] MODE_FW_MASTER   = 4'hb;
    localparam logic [3:0] MODE_SLAVE7_SS   = 4'he;
    localparam logic [3:0] MODE_SLAVE10_SS  = 4'hf;

    // Bit counts within one byte frame on the bus.
    localparam logic [3:0] CNT_ZERO         = 4'h0;
    localparam logic [3:0] CNT_LAST_TX_SHIFT = 4'h7;
    localparam logic [3:0] CNT_BYTE_DONE    = 4'h8;
    localparam logic [3:0] CNT_ACK_SLOT     = 4'h9;

    // Leading pattern of the first byte of a 10-bit address.
    localparam logic [4:0] TEN_BIT_TAG      = 5'h1e;

    // Positions inside the pin direction input.
    localparam int unsigned PIN_SCL         = 0;
    localparam int unsigned PIN_SDA         = 1;

    // Values after reset.
    localparam logic [7:0] BYTE_RESET       = 8'h00;
    localparam logic [3:0] MODE_RESET       = 4'h0;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_ADDR2,
        PH_RX,
        PH_TX,
        PH_MASTER
    } phase_e;

    // Status register view of the port.
    typedef struct packed {
        logic data_not_address;
        logic stop_seen;
        logic start_seen;
        logic read_write;
        logic update_address_flag;
        logic buffer_full_flag;
    } status_s;

    localparam status_s STATUS_RESET = '0;

    // Software data path into the port.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_wr_s;

endpackage : i2c_slave_port_pkg

// >>> i2c_slave_port_logic.sv
`timescale 1ns/1ps
// Functional notes
// - Ack matched address or data, then buffer it.
// - Full or overflowed: no ack, keep buffer, interrupt.
// - Buffer read clears full; overflow cleared by software.
// - After enable, wait START, then shift eight bits.
// - Sample SDA on rising SCL.
// - Compare shift bits 7:1 at eighth falling edge.
// - Match: load, set full, ack, interrupt ninth fall.
// - 10-bit first byte is 11110, A9, A8, write.
// - High byte: flags set, hold SCL until address rewrite.
// - Low byte: flags set, rewrite high byte releases SCL.
// - Repeated START read: interrupt and full, no update flag.
// - Write address: clear direction bit, buffer the address.
// - Interrupt every byte of a matched transfer; software clears it.
// - Read address: set direction, buffer, ack, hold SCL.
// - Transmit write loads shifter; clock release frees SCL.
// - Transmit bits change on falling SCL.
// - Master ack at ninth rise; high ends, low continues.
// - START/STOP seen bits cleared at reset or disable.
// - Master drives lines low only, by direction bit.
// - Master support: interrupt on START, STOP, each byte.
module i2c_slave_port_logic (
    input  wire logic                          clk_i,
    input  wire logic                          resetn_i,
    input  wire logic                          scl_clk_i,
    input  wire logic                          sda_i,
    output wire logic                          scl_o,
    output logic                               scl_oe_n_o,
    output wire logic                          sda_o,
    output logic                               sda_oe_n_o,
    input  wire logic                          port_enable_bit_i,
    input  wire logic [3:0]                    port_mode_select_i,
    input  wire logic [1:0]                    pin_direction_register_i,
    input  wire logic                          clock_release_set_i,
    input  wire i2c_slave_port_pkg::byte_wr_s  buffer_write_i,
    input  wire logic                          buffer_read_i,
    input  wire i2c_slave_port_pkg::byte_wr_s  address_write_i,
    input  wire logic                          overflow_clear_i,
    input  wire logic                          interrupt_clear_i,
    output logic [7:0]                         serial_rx_tx_buffer_o,
    output logic [7:0]                         slave_address_register_o,
    output i2c_slave_port_pkg::status_s        serial_status_register_o,
    output logic                               receive_overflow_flag_o,
    output logic                               clock_release_bit_o,
    output logic                               port_interrupt_flag_o
);
    import i2c_slave_port_pkg::*;

    // Link domain: one flop pair clocked by SCL itself.
    logic       link_bit_reg;
    logic       link_tgl_reg;

    always_ff @(posedge scl_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link_bit_reg <= 1'b0;
            link_tgl_reg <= 1'b0;
        end else begin
            link_bit_reg <= sda_i;
            link_tgl_reg <= ~link_tgl_reg;
        end
    end

    // Synchronisers into the system clock domain.
    logic       tgl_s1_reg;
    logic       tgl_s2_reg;
    logic       tgl_s3_reg;
    logic       scl_s1_reg;
    logic       scl_s2_reg;
    logic       scl_s3_reg;
    logic       sda_s1_reg;
    logic       sda_s2_reg;
    logic       sda_s3_reg;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_s3_reg <= 1'b0;
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_s3_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
        end else begin
            tgl_s1_reg <= link_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
            scl_s1_reg <= scl_clk_i;
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            sda_s1_reg <= sda_i;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
        end
    end

    // The sampled bit is stable long before its toggle is seen here, so it is read without further staging.
    logic rise_ev;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    assign rise_ev  = tgl_s2_reg ^ tgl_s3_reg;
    assign scl_fall = scl_s3_reg & ~scl_s2_reg;
    assign start_ev = port_enable_bit_i & scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
    assign stop_ev  = port_enable_bit_i & scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

    phase_e     phase_reg;
    phase_e     pend_phase_reg;
    logic [3:0] cnt_reg;
    logic [7:0] rx_sr_reg;
    logic [7:0] tx_sr_reg;
    logic [7:0] buf_reg;
    logic [7:0] addr_reg;
    status_s    status_reg;
    logic       ov_reg;
    logic       irq_reg;
    logic       ckp_reg;
    logic       prior_reg;
    logic       ack_drive_reg;
    logic       ua_hold_reg;
    logic       pend_ours_reg;
    logic       pend_hold_reg;

    logic master_only;
    logic ten_bit;
    logic ss_irq;
    logic room;
    logic byte_end;
    logic ack_end;
    logic tx_nack;

    assign master_only = port_mode_select_i == MODE_FW_MASTER;
    assign ten_bit     = (port_mode_select_i == MODE_SLAVE10) || (port_mode_select_i == MODE_SLAVE10_SS);
    assign ss_irq      = (port_mode_select_i == MODE_SLAVE7_SS) || (port_mode_select_i == MODE_SLAVE10_SS)
                         || master_only;
    assign room        = ~status_reg.buffer_full_flag & ~ov_reg;
    assign byte_end    = scl_fall && (phase_reg != PH_IDLE) && (cnt_reg == CNT_BYTE_DONE);
    assign ack_end     = scl_fall && (phase_reg != PH_IDLE) && (cnt_reg == CNT_ACK_SLOT);
    assign tx_nack     = rise_ev && (phase_reg == PH_TX) && (cnt_reg == CNT_BYTE_DONE) && link_bit_reg;

    // Decision taken at the falling edge of the eighth clock of a byte.
    logic   acc_load;
    logic   acc_ov;
    logic   acc_ua;
    logic   acc_ours;
    logic   acc_addr;
    logic   acc_rw;
    logic   acc_hold;
    logic   acc_prior_set;
    logic   acc_prior_clr;
    phase_e acc_next;
    logic   hi_ok;
    logic   addr7_ok;

    assign addr7_ok = rx_sr_reg[7:1] == addr_reg[7:1];
    assign hi_ok    = addr7_ok && (rx_sr_reg[7:3] == TEN_BIT_TAG);

    always_comb begin
        acc_load      = 1'b0;
        acc_ov        = 1'b0;
        acc_ua        = 1'b0;
        acc_ours      = 1'b0;
        acc_addr      = 1'b0;
        acc_hold      = 1'b0;
        acc_prior_set = 1'b0;
        acc_prior_clr = 1'b0;
        acc_next      = PH_IDLE;
        unique case (phase_reg)
            PH_IDLE: begin
                acc_next = PH_IDLE;
            end
            PH_ADDR: begin
                if (ten_bit) begin
                    if (hi_ok && !rx_sr_reg[0]) begin
                        acc_ours      = 1'b1;
                        acc_addr      = 1'b1;
                        acc_prior_clr = 1'b1;
                        if (room) begin
                            acc_load = 1'b1;
                            acc_ua   = 1'b1;
                            acc_hold = 1'b1;
                            acc_next = PH_ADDR2;
                        end else begin
                            acc_ov = 1'b1;
                        end
                    end else if (hi_ok && prior_reg) begin
                        acc_ours = 1'b1;
                        acc_addr = 1'b1;
                        if (room) begin
                            acc_load = 1'b1;
                            acc_next = PH_TX;
                        end else begin
                            acc_ov = 1'b1;
                        end
                    end else begin
                        acc_prior_clr = 1'b1;
                    end
                end else if (addr7_ok) begin
                    acc_ours = 1'b1;
                    acc_addr = 1'b1;
                    if (room) begin
                        acc_load = 1'b1;
                        acc_next = rx_sr_reg[0] ? PH_TX : PH_RX;
                    end else begin
                        acc_ov = 1'b1;
                    end
                end
            end
            PH_ADDR2: begin
                acc_ours = 1'b1;
                acc_addr = 1'b1;
                acc_ua   = 1'b1;
                if (rx_sr_reg == addr_reg) begin
                    if (room) begin
                        acc_load      = 1'b1;
                        acc_prior_set = 1'b1;
                        acc_hold      = 1'b1;
                        acc_next      = PH_RX;
                    end else begin
                        acc_ov = 1'b1;
                    end
                end
            end
            PH_RX: begin
                acc_ours = 1'b1;
                acc_next = PH_RX;
                if (room) begin
                    acc_load = 1'b1;
                end else begin
                    acc_ov = 1'b1;
                end
            end
            PH_TX: begin
                acc_ours = 1'b1;
                acc_next = PH_TX;
            end
            PH_MASTER: begin
                acc_ours = 1'b1;
                acc_next = PH_MASTER;
            end
        endcase
        acc_rw = acc_load && (phase_reg == PH_ADDR);
    end

    // Bus phase.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_reg <= PH_IDLE;
        end else if (!port_enable_bit_i || stop_ev) begin
            phase_reg <= PH_IDLE;
        end else if (start_ev) begin
            phase_reg <= master_only ? PH_MASTER : PH_ADDR;
        end else if (tx_nack) begin
            phase_reg <= PH_IDLE;
        end else if (ack_end) begin
            phase_reg <= pend_phase_reg;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_phase_reg <= PH_IDLE;
            pend_ours_reg  <= 1'b0;
            pend_hold_reg  <= 1'b0;
        end else if (byte_end) begin
            pend_phase_reg <= acc_next;
            pend_ours_reg  <= acc_ours;
            pend_hold_reg  <= acc_hold;
        end
    end

    // Bit counter: 1..8 data bits, 9 is the acknowledge slot.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= CNT_ZERO;
        end else if (start_ev || phase_reg == PH_IDLE || ack_end) begin
            cnt_reg <= CNT_ZERO;
        end else if (rise_ev && cnt_reg != CNT_ACK_SLOT) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_sr_reg <= BYTE_RESET;
        end else if (rise_ev && phase_reg != PH_IDLE && cnt_reg < CNT_BYTE_DONE) begin
            rx_sr_reg <= {rx_sr_reg[6:0], link_bit_reg};
        end
    end

    // Transmit shifter; the first bit stands on SDA while SCL is still held low.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_sr_reg <= BYTE_RESET;
        end else if (buffer_write_i.valid) begin
            tx_sr_reg <= buffer_write_i.data;
        end else if (scl_fall && phase_reg == PH_TX && cnt_reg != CNT_ZERO && cnt_reg <= CNT_BYTE_DONE) begin
            tx_sr_reg <= {tx_sr_reg[6:0], 1'b1};
        end
    end

    // The hardware load takes priority over a software write landing in the same cycle.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            buf_reg <= BYTE_RESET;
        end else if (byte_end && acc_load) begin
            buf_reg <= rx_sr_reg;
        end else if (buffer_write_i.valid) begin
            buf_reg <= buffer_write_i.data;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_reg <= BYTE_RESET;
        end else if (address_write_i.valid) begin
            addr_reg <= address_write_i.data;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prior_reg <= 1'b0;
        end else if (!port_enable_bit_i) begin
            prior_reg <= 1'b0;
        end else if (byte_end && acc_prior_set) begin
            prior_reg <= 1'b1;
        end else if (byte_end && acc_prior_clr) begin
            prior_reg <= 1'b0;
        end
    end

    // Status flags; a hardware set always beats a software clear.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_reg <= STATUS_RESET;
        end else if (!port_enable_bit_i) begin
            status_reg <= STATUS_RESET;
        end else begin
            if (start_ev) begin
                status_reg.start_seen <= 1'b1;
                status_reg.stop_seen  <= 1'b0;
            end else if (stop_ev) begin
                status_reg.stop_seen  <= 1'b1;
                status_reg.start_seen <= 1'b0;
            end
            if (tx_nack) begin
                status_reg.buffer_full_flag    <= 1'b0;
                status_reg.read_write          <= 1'b0;
                status_reg.update_address_flag <= 1'b0;
                status_reg.data_not_address    <= 1'b0;
            end else begin
                if (byte_end && acc_load) begin
                    status_reg.buffer_full_flag <= 1'b1;
                    status_reg.data_not_address <= ~acc_addr;
                end else if (buffer_read_i) begin
                    status_reg.buffer_full_flag <= 1'b0;
                end
                if (byte_end && acc_rw) begin
                    status_reg.read_write <= rx_sr_reg[0];
                end
                if (byte_end && acc_ua) begin
                    status_reg.update_address_flag <= 1'b1;
                end else if (address_write_i.valid) begin
                    status_reg.update_address_flag <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ov_reg <= 1'b0;
        end else if (!port_enable_bit_i) begin
            ov_reg <= 1'b0;
        end else if (byte_end && acc_ov) begin
            ov_reg <= 1'b1;
        end else if (overflow_clear_i) begin
            ov_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_reg <= 1'b0;
        end else if ((ack_end && pend_ours_reg) || tx_nack) begin
            irq_reg <= 1'b1;
        end else if ((start_ev || stop_ev) && ss_irq) begin
            irq_reg <= 1'b1;
        end else if (interrupt_clear_i) begin
            irq_reg <= 1'b0;
        end
    end

    // Software release wins here so a release issued at the ninth fall is not swallowed.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ckp_reg <= 1'b1;
        end else if (clock_release_set_i) begin
            ckp_reg <= 1'b1;
        end else if (ack_end && pend_phase_reg == PH_TX) begin
            ckp_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_drive_reg <= 1'b0;
        end else if (!port_enable_bit_i || start_ev || stop_ev || ack_end) begin
            ack_drive_reg <= 1'b0;
        end else if (byte_end && acc_load) begin
            ack_drive_reg <= 1'b1;
        end
    end

    // The address update hold ends when software rewrites the address register.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ua_hold_reg <= 1'b0;
        end else if (!port_enable_bit_i || start_ev || stop_ev) begin
            ua_hold_reg <= 1'b0;
        end else if (ack_end && pend_hold_reg) begin
            ua_hold_reg <= 1'b1;
        end else if (address_write_i.valid) begin
            ua_hold_reg <= 1'b0;
        end
    end

    // Pin drive; lines are only ever pulled low.
    logic slave_sda_low;
    logic slave_scl_low;
    logic sda_low_next;
    logic scl_low_next;

    assign slave_sda_low = ack_drive_reg
                           || (phase_reg == PH_TX && cnt_reg <= CNT_BYTE_DONE && !tx_sr_reg[7]);
    assign slave_scl_low = ua_hold_reg
                           || (phase_reg == PH_TX && cnt_reg == CNT_ZERO && !ckp_reg);
    assign sda_low_next  = port_enable_bit_i && (slave_sda_low || !pin_direction_register_i[PIN_SDA]);
    assign scl_low_next  = port_enable_bit_i && (slave_scl_low || !pin_direction_register_i[PIN_SCL]);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sda_oe_n_o <= 1'b1;
            scl_oe_n_o <= 1'b1;
        end else begin
            sda_oe_n_o <= ~sda_low_next;
            scl_oe_n_o <= ~scl_low_next;
        end
    end

    assign sda_o = 1'b0;
    assign scl_o = 1'b0;

    assign serial_rx_tx_buffer_o    = buf_reg;
    assign slave_address_register_o = addr_reg;
    assign serial_status_register_o = status_reg;
    assign receive_overflow_flag_o  = ov_reg;
    assign clock_release_bit_o      = ckp_reg;
    assign port_interrupt_flag_o    = irq_reg;

endmodule : i2c_slave_port_logic

// >>> i2c_slave_port_logic_props.sv
`timescale 1ns/1ps
module i2c_slave_port_logic_props
    import i2c_slave_port_pkg::*;
(
    input wire logic                        clk_i,
    input wire logic                        resetn_i,
    input wire logic                        port_enable_bit_i,
    input wire logic [3:0]                  port_mode_select_i,
    input wire logic                        clock_release_set_i,
    input wire logic                        buffer_read_i,
    input wire logic                        overflow_clear_i,
    input wire logic                        interrupt_clear_i,
    input wire logic                        scl_oe_n_o,
    input wire logic                        sda_oe_n_o,
    input wire i2c_slave_port_pkg::status_s serial_status_register_o,
    input wire logic                        receive_overflow_flag_o,
    input wire logic                        clock_release_bit_o,
    input wire logic                        port_interrupt_flag_o
);
    import i2c_slave_port_pkg::*;
    status_s st;
    assign st = serial_status_register_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_off; !port_enable_bit_i [*2] |-> scl_oe_n_o && sda_oe_n_o && !st.start_seen && !st.stop_seen; endproperty
    a_off: assert property (p_off) else $error("disabled port not idle");
    property p_rd; buffer_read_i && sda_oe_n_o |=> !st.buffer_full_flag || !sda_oe_n_o; endproperty
    a_rd: assert property (p_rd) else $error("read left buffer full");
    property p_oc; overflow_clear_i |=> !receive_overflow_flag_o; endproperty
    a_oc: assert property (p_oc) else $error("overflow not cleared");
    property p_ov; receive_overflow_flag_o && !overflow_clear_i && port_enable_bit_i |=> receive_overflow_flag_o; endproperty
    a_ov: assert property (p_ov) else $error("overflow dropped");
    property p_irq; port_interrupt_flag_o && !interrupt_clear_i && port_enable_bit_i |=> port_interrupt_flag_o; endproperty
    a_irq: assert property (p_irq) else $error("interrupt dropped");
    property p_ack;
        $fell(sda_oe_n_o) && !st.read_write && port_mode_select_i != MODE_FW_MASTER
            |-> st.buffer_full_flag && !receive_overflow_flag_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack without load");
    property p_ck; clock_release_set_i && port_enable_bit_i |=> clock_release_bit_o; endproperty
    a_ck: assert property (p_ck) else $error("clock release lost");
    property p_hold;
        $fell(scl_oe_n_o) && port_mode_select_i != MODE_FW_MASTER |-> !clock_release_bit_o || st.update_address_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("clock held without cause");
endmodule : i2c_slave_port_logic_props
bind i2c_slave_port_logic i2c_slave_port_logic_props i2c_slave_port_logic_props_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .port_enable_bit_i(port_enable_bit_i),
    .port_mode_select_i(port_mode_select_i), .clock_release_set_i(clock_release_set_i),
    .buffer_read_i(buffer_read_i), .overflow_clear_i(overflow_clear_i), .interrupt_clear_i(interrupt_clear_i),
    .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o), .serial_status_register_o(serial_status_register_o),
    .receive_overflow_flag_o(receive_overflow_flag_o), .clock_release_bit_o(clock_release_bit_o),
    .port_interrupt_flag_o(port_interrupt_flag_o));

// >>> i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
    output logic      scl_m_o,
    output logic      sda_m_o,
    output logic      stuck_o,
    input  wire logic scl_i,
    input  wire logic sda_i
);
    initial begin
        scl_m_o = 1'b1;
        sda_m_o = 1'b1;
        stuck_o = 1'b0;
    end
    task automatic bit_x(input logic b, output logic r);
        sda_m_o = b;
        #16;
        scl_m_o = 1'b1;
        // The high time only starts once a stretching slave lets the line up.
        for (int i = 0; i < 4000 && !scl_i; i++) #4;
        stuck_o |= !scl_i;
        #12;
        r = sda_i;
        scl_m_o = 1'b0;
    endtask : bit_x
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], r);
            rx = {rx[6:0], r};
        end
        bit_x(ack_in, ack);
    endtask : xfer
    task automatic start_c;
        #6;
        sda_m_o = 1'b1;
        #16;
        scl_m_o = 1'b1;
        #32;
        sda_m_o = 1'b0;
        #32;
        scl_m_o = 1'b0;
    endtask : start_c
    task automatic stop_c;
        sda_m_o = 1'b0;
        #16;
        scl_m_o = 1'b1;
        #32;
        sda_m_o = 1'b1;
        #32;
    endtask : stop_c
endmodule : i2c_master_model

// >>> tb_i2c_slave_port_logic.sv
`timescale 1ns/1ps
module tb_i2c_slave_port_logic;
    import i2c_slave_port_pkg::*;
    localparam logic [5:0] RD = 6'h20, WR = 6'h10, AD = 6'h08, CK = 6'h04, OC = 6'h02, IC = 6'h01;
    logic clk_i = 1'b0, resetn_i = 1'b0, port_enable_bit_i = 1'b1, stuck, scl_m, sda_m, scl_o, sda_o;
    logic scl_oe_n, sda_oe_n, ovf, clock_release_bit, irq, k;
    logic [3:0] port_mode_select_i = MODE_SLAVE7;
    logic [1:0] pin_direction_register_i = 2'b11;
    logic [5:0] swp = 6'h00;
    logic [7:0] swd = 8'h00, buf_o, addr_o, m_buf, r, t;
    logic [6:0] a;
    status_s st;
    bit m_bf, m_ovf;
    int num_errors = 0, cmp_count = 0;
    wire scl_w = scl_m & (scl_oe_n | scl_o);
    wire sda_w = sda_m & (sda_oe_n | sda_o);
    always #2 clk_i = ~clk_i;
    i2c_slave_port_logic i2c_slave_port_logic_inst (.clk_i(clk_i), .resetn_i(resetn_i), .scl_clk_i(scl_w),
        .sda_i(sda_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
        .port_enable_bit_i(port_enable_bit_i), .port_mode_select_i(port_mode_select_i),
        .pin_direction_register_i(pin_direction_register_i), .clock_release_set_i(swp[2]),
        .buffer_write_i({swp[4], swd}), .buffer_read_i(swp[5]), .address_write_i({swp[3], swd}),
        .overflow_clear_i(swp[1]), .interrupt_clear_i(swp[0]), .serial_rx_tx_buffer_o(buf_o),
        .slave_address_register_o(addr_o), .serial_status_register_o(st), .receive_overflow_flag_o(ovf),
        .clock_release_bit_o(clock_release_bit), .port_interrupt_flag_o(irq));
    i2c_master_model i2c_master_model_inst (.scl_m_o(scl_m), .sda_m_o(sda_m), .stuck_o(stuck), .scl_i(scl_w),
        .sda_i(sda_w));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic sw(input logic [5:0] p, input logic [7:0] d);
        @(posedge clk_i);
        swp <= p;
        swd <= d;
        @(posedge clk_i);
        swp <= 6'h00;
        #9;
    endtask : sw
    task automatic rx_byte(input logic [7:0] d, input bit hit);
        bit e;
        e = !hit || m_bf || m_ovf;
        i2c_master_model_inst.xfer(d, 1'b1, r, k);
        repeat (8) @(posedge clk_i);
        if (hit && !e) begin
            m_buf = d;
            m_bf = 1'b1;
        end else if (hit) begin
            m_ovf = 1'b1;
        end
        chk({7'h0, k}, {7'h0, e});
        chk(buf_o, m_buf);
        chk({5'h0, st.buffer_full_flag, ovf, irq}, {5'h0, m_bf, m_ovf, hit});
        sw(IC, 8'h00);
    endtask : rx_byte
    task automatic tally_and_finish;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h76b0d8f7));
        a = 7'($urandom);
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        sw(AD, {a, 1'b0});
        i2c_master_model_inst.start_c();
        rx_byte({a, 1'b0}, 1'b1);
        chk({7'h0, st.read_write}, 8'h00);
        sw(RD, 8'h00);
        m_bf = 1'b0;
        rx_byte(8'($urandom), 1'b1);
        chk({7'h0, st.data_not_address}, 8'h01);
        rx_byte(8'($urandom), 1'b1);
        sw(RD, 8'h00);
        m_bf = 1'b0;
        rx_byte(8'($urandom), 1'b1);
        sw(OC, 8'h00);
        m_ovf = 1'b0;
        chk({6'h0, st.buffer_full_flag, ovf}, 8'h00);
        i2c_master_model_inst.stop_c();
        i2c_master_model_inst.start_c();
        rx_byte({~a, 1'b0}, 1'b0);
        i2c_master_model_inst.stop_c();
        i2c_master_model_inst.start_c();
        rx_byte({a, 1'b1}, 1'b1);
        chk({6'h0, st.read_write, clock_release_bit}, 8'h02);
        sw(RD, 8'h00);
        m_bf = 1'b0;
        for (int i = 0; i < 2; i++) begin
            t = 8'($urandom);
            sw(WR, t);
            sw(CK, t);
            i2c_master_model_inst.xfer(8'hff, i[0], r, k);
            repeat (8) @(posedge clk_i);
            chk(r, t);
            chk({6'h0, st.read_write, clock_release_bit}, i ? 8'h01 : 8'h02);
        end
        i2c_master_model_inst.stop_c();
        @(posedge clk_i);
        port_enable_bit_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({6'h0, st.start_seen, st.stop_seen}, 8'h00);
        port_enable_bit_i <= 1'b1;
        port_mode_select_i <= MODE_SLAVE7_SS;
        sw(IC, 8'h00);
        i2c_master_model_inst.start_c();
        repeat (8) @(posedge clk_i);
        chk({6'h0, st.start_seen, irq}, 8'h03);
        i2c_master_model_inst.stop_c();
        repeat (8) @(posedge clk_i);
        chk({7'h0, st.stop_seen}, 8'h01);
        port_mode_select_i <= MODE_FW_MASTER;
        pin_direction_register_i <= 2'b01;
        repeat (8) @(posedge clk_i);
        chk({5'h0, stuck, scl_oe_n, sda_oe_n}, 8'h02);
        tally_and_finish();
    end
endmodule : tb_i2c_slave_port_logic
